/* File: hw/ued_endpoint_desc.sv */
// Endpoint descriptor fields with buffer manager handshake logic
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module ued_endpoint_desc #(
   parameter int WB_AW = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Input endpoint transaction side
   input wire logic in_tok_i,
   input wire logic in_done_i,
   input wire logic in_stall_set_i,
   output ued_pkg::ued_hs_t in_hs_o,
   output logic in_resp_o,
   output logic [ued_pkg::ADDR_BITS-1:0] in_addr_o,
   output logic [6:0] in_cnt_o,
   // Output endpoint transaction side
   input wire logic out_tok_i,
   input wire logic out_done_i,
   input wire logic [6:0] out_len_i,
   input wire logic out_buffer_manager_enable_i,
   input wire logic out_irq_en_i,
   output ued_pkg::ued_hs_t out_hs_o,
   output logic out_resp_o,
   output logic [ued_pkg::ADDR_BITS-1:0] out_addr_o,
   output logic [6:0] out_size_o,
   // Interrupt
   output logic irq_o
);
   import ued_pkg::*;

   // ************************************************************
   // Elaboration check
   // ************************************************************
   if (WB_AW < 7) begin : g_bad_aw
      $error("WB_AW must be at least 7");
   end

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [ADDR_BITS-1:0] start_addr(input logic [7:0] base);
      start_addr = {base, {PAD_BITS{1'b0}}};
   endfunction : start_addr

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0] in_cfg_r;
   logic [7:0] in_x_base_r;
   logic [7:0] in_x_cnt_r;
   logic [7:0] in_y_base_r;
   logic [7:0] in_y_cnt_r;
   logic [7:0] out_y_base_r;
   logic [7:0] out_y_cnt_r;
   logic [6:0] out_size_r;
   logic [IRQ_BITS-1:0] irq_stat_r;
   logic [IRQ_BITS-1:0] irq_en_r;
   logic in_sel_y_r;
   logic in_pend_r;
   logic ack_r;
   logic [31:0] rdat_r;
   ued_hs_t in_hs_r;
   logic in_resp_r;
   logic [ADDR_BITS-1:0] in_addr_r;
   logic [6:0] in_cnt_r;
   ued_hs_t out_hs_r;
   logic out_resp_r;
   logic [ADDR_BITS-1:0] out_addr_r;
   logic [6:0] out_size_out_r;
   logic irq_r;

   // ************************************************************
   // Bus decode
   // ************************************************************
   logic bus_req;
   logic wr_en;
   logic [4:0] idx;
   logic [7:0] wbyte;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
   assign idx = wb_adr_i[6:2];
   assign wbyte = wb_dat_i[7:0];

   // ************************************************************
   // Transaction decode
   // ************************************************************
   logic in_buffer_manager_enable;
   logic in_stall;
   logic in_use_y;
   logic in_nak;
   logic in_stall_hit;
   logic in_ack_hit;
   logic in_done_hit;
   logic out_ack_hit;
   logic out_done_hit;

   assign in_buffer_manager_enable = in_cfg_r[CFG_BUFFER_MANAGER_ENABLE_BIT];
   assign in_stall = in_cfg_r[CFG_STALL_BIT];
   assign in_use_y = in_cfg_r[CFG_DOUBLE_BUFFER_ENABLE_BIT] & in_cfg_r[CFG_TOGGLE_BIT];
   assign in_nak = in_use_y ? in_y_cnt_r[CNT_NAK_BIT] : in_x_cnt_r[CNT_NAK_BIT];
   assign in_stall_hit = in_tok_i & in_buffer_manager_enable & in_stall;
   assign in_ack_hit = in_tok_i & in_buffer_manager_enable & ~in_stall & ~in_nak;
   assign in_done_hit = in_done_i & in_pend_r;
   assign out_ack_hit = out_tok_i & out_buffer_manager_enable_i & ~out_y_cnt_r[CNT_NAK_BIT];
   assign out_done_hit = out_done_i & out_buffer_manager_enable_i;

   // ************************************************************
   // Wishbone answer
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   // Unmapped and write-only locations read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_r <= 32'h0000_0000;
      end else if (bus_req) begin
         rdat_r <= 32'h0000_0000;
         unique case (idx)
            IDX_IN_CFG: rdat_r[7:0] <= {in_cfg_r[7:2], 2'b00};
            IDX_IN_X_BASE: rdat_r[7:0] <= in_x_base_r;
            IDX_IN_X_CNT: rdat_r[7:0] <= in_x_cnt_r;
            IDX_IN_Y_BASE: rdat_r[7:0] <= in_y_base_r;
            IDX_IN_Y_CNT: rdat_r[7:0] <= in_y_cnt_r;
            IDX_OUT_Y_BASE: rdat_r[7:0] <= out_y_base_r;
            IDX_OUT_Y_CNT: rdat_r[7:0] <= out_y_cnt_r;
            IDX_OUT_SIZE: rdat_r[7:0] <= {1'b0, out_size_r};
            IDX_IRQ_STAT: rdat_r[IRQ_BITS-1:0] <= irq_stat_r;
            IDX_IRQ_EN: rdat_r[IRQ_BITS-1:0] <= irq_en_r;
            default: rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Base address and output size fields
   // ************************************************************
   // base only firmware written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_x_base_r <= REG_RST;
         in_y_base_r <= REG_RST;
         out_y_base_r <= REG_RST;
         out_size_r <= REG_RST[6:0];
      end else if (wr_en) begin
         if (idx == IDX_IN_X_BASE) begin
            in_x_base_r <= wbyte;
         end
         if (idx == IDX_IN_Y_BASE) begin
            in_y_base_r <= wbyte;
         end
         if (idx == IDX_OUT_Y_BASE) begin
            out_y_base_r <= wbyte;
         end
         if (idx == IDX_OUT_SIZE) begin
            out_size_r <= wbyte[6:0];
         end
      end
   end

   // ************************************************************
   // Input configuration
   // ************************************************************
   // Hardware events come last so they win over a firmware write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_cfg_r <= REG_RST;
      end else begin
         if (wr_en && idx == IDX_IN_CFG) begin
            in_cfg_r <= {wbyte[7:2], 2'b00};
         end
         if (in_stall_set_i) begin
            in_cfg_r[CFG_STALL_BIT] <= 1'b1;
         end else if (in_stall_hit) begin
            in_cfg_r[CFG_STALL_BIT] <= 1'b0;
         end
         if (in_done_hit) begin
            in_cfg_r[CFG_TOGGLE_BIT] <= ~in_cfg_r[CFG_TOGGLE_BIT];
         end
      end
   end

   // ************************************************************
   // Input byte counts
   // ************************************************************
   // counts above 64 are not checked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_x_cnt_r <= REG_RST;
         in_y_cnt_r <= REG_RST;
      end else begin
         if (wr_en && idx == IDX_IN_X_CNT) begin
            in_x_cnt_r <= wbyte;
         end
         if (wr_en && idx == IDX_IN_Y_CNT) begin
            in_y_cnt_r <= wbyte;
         end
         if (in_done_hit && !in_sel_y_r) begin
            in_x_cnt_r[CNT_NAK_BIT] <= 1'b1;
         end
         if (in_done_hit && in_sel_y_r) begin
            in_y_cnt_r[CNT_NAK_BIT] <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Output byte count
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_y_cnt_r <= REG_RST;
      end else if (out_done_hit) begin
         out_y_cnt_r <= {1'b1, out_len_i};
      end else if (wr_en && idx == IDX_OUT_Y_CNT) begin
         out_y_cnt_r <= wbyte;
      end
   end

   // ************************************************************
   // Input transaction answer
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_hs_r <= UED_HS_NONE;
         in_resp_r <= 1'b0;
         in_addr_r <= '0;
         in_cnt_r <= 7'h00;
         in_sel_y_r <= 1'b0;
         in_pend_r <= 1'b0;
      end else begin
         in_resp_r <= in_tok_i & in_buffer_manager_enable;
         if (in_done_i) begin
            in_pend_r <= 1'b0;
         end
         if (in_tok_i) begin
            if (!in_buffer_manager_enable) begin
               in_hs_r <= UED_HS_NONE;
            end else if (in_stall) begin
               in_hs_r <= UED_HS_STALL;
            end else if (in_nak) begin
               in_hs_r <= UED_HS_NAK;
            end else begin
               in_hs_r <= UED_HS_ACK;
            end
         end
         if (in_ack_hit) begin
            in_addr_r <= start_addr(in_use_y ? in_y_base_r : in_x_base_r);
            in_cnt_r <= in_use_y ? in_y_cnt_r[6:0] : in_x_cnt_r[6:0];
            in_sel_y_r <= in_use_y;
            in_pend_r <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Output transaction answer
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_hs_r <= UED_HS_NONE;
         out_resp_r <= 1'b0;
         out_addr_r <= '0;
         out_size_out_r <= 7'h00;
      end else begin
         out_resp_r <= out_tok_i & out_buffer_manager_enable_i;
         if (out_tok_i) begin
            if (!out_buffer_manager_enable_i) begin
               out_hs_r <= UED_HS_NONE;
            end else if (out_y_cnt_r[CNT_NAK_BIT]) begin
               out_hs_r <= UED_HS_NAK;
            end else begin
               out_hs_r <= UED_HS_ACK;
            end
         end
         if (out_ack_hit) begin
            out_addr_r <= start_addr(out_y_base_r);
            out_size_out_r <= out_size_r;
         end
      end
   end

   // ************************************************************
   // Interrupt status
   // ************************************************************
   // Set wins over clear so no event is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= IRQ_RST;
         irq_en_r <= IRQ_RST;
      end else begin
         if (wr_en && idx == IDX_IRQ_EN) begin
            irq_en_r <= wbyte[IRQ_BITS-1:0];
         end
         if (wr_en && idx == IDX_IRQ_CLR) begin
            irq_stat_r <= irq_stat_r & ~wbyte[IRQ_BITS-1:0];
         end
         if (in_done_hit && in_cfg_r[CFG_IRQ_EN_BIT]) begin
            irq_stat_r[IRQ_IN_DONE_BIT] <= 1'b1;
         end
         if (out_done_hit && out_irq_en_i) begin
            irq_stat_r[IRQ_OUT_DONE_BIT] <= 1'b1;
         end
         if (in_stall_hit) begin
            irq_stat_r[IRQ_STALL_BIT] <= 1'b1;
         end
      end
   end

   // One cycle behind status, traded for a flop-driven output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_en_r);
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign in_hs_o = in_hs_r;
   assign in_resp_o = in_resp_r;
   assign in_addr_o = in_addr_r;
   assign in_cnt_o = in_cnt_r;
   assign out_hs_o = out_hs_r;
   assign out_resp_o = out_resp_r;
   assign out_addr_o = out_addr_r;
   assign out_size_o = out_size_out_r;
   assign irq_o = irq_r;

endmodule : ued_endpoint_desc

`default_nettype wire

/* File: hw/ued_pkg.sv */
// Package with register map, field layout and handshake codes of the descriptor block
package ued_pkg;

   // ************************************************************
   // Register indices, byte address is four times the index
   // ************************************************************
   localparam logic [4:0] IDX_IN_CFG = 5'h00;
   localparam logic [4:0] IDX_IN_X_BASE = 5'h01;
   localparam logic [4:0] IDX_IN_X_CNT = 5'h02;
   localparam logic [4:0] IDX_IN_Y_BASE = 5'h05;
   localparam logic [4:0] IDX_IN_Y_CNT = 5'h06;
   localparam logic [4:0] IDX_OUT_Y_BASE = 5'h0D;
   localparam logic [4:0] IDX_OUT_Y_CNT = 5'h0E;
   localparam logic [4:0] IDX_OUT_SIZE = 5'h0F;
   localparam logic [4:0] IDX_IRQ_STAT = 5'h10;
   localparam logic [4:0] IDX_IRQ_EN = 5'h11;
   localparam logic [4:0] IDX_IRQ_CLR = 5'h12;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CFG_IRQ_EN_BIT = 2;
   localparam int CFG_STALL_BIT = 3;
   localparam int CFG_DOUBLE_BUFFER_ENABLE_BIT = 4;
   localparam int CFG_TOGGLE_BIT = 5;
   localparam int CFG_ISO_BIT = 6;
   localparam int CFG_BUFFER_MANAGER_ENABLE_BIT = 7;
   localparam int CNT_NAK_BIT = 7;
   localparam int IRQ_IN_DONE_BIT = 0;
   localparam int IRQ_OUT_DONE_BIT = 1;
   localparam int IRQ_STALL_BIT = 2;
   localparam int IRQ_BITS = 3;

   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int ADDR_BITS = 11;
   localparam int PAD_BITS = 3;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [IRQ_BITS-1:0] IRQ_RST = 3'h0;
   localparam logic [6:0] MAX_COUNT = 7'h40;

   // ************************************************************
   // Handshake answer codes
   // ************************************************************
   typedef enum logic [1:0] {
      UED_HS_NONE = 2'b00,
      UED_HS_ACK = 2'b01,
      UED_HS_NAK = 2'b10,
      UED_HS_STALL = 2'b11
   } ued_hs_t;

endpackage : ued_pkg

/* File: test/tb_ued_endpoint_desc.sv */
// Testbench for the endpoint descriptor block
`timescale 1ns/10ps
`default_nettype none
module tb_ued_endpoint_desc;
   import ued_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic stall_set = 1'b0;
   logic buffer_manager_enable = 1'b0;
   logic oirq = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, in_tok, in_done, out_tok, out_done, in_resp_o, out_resp_o, irq_o, got;
   logic [6:0] out_len, in_cnt_o, out_size_o;
   logic [10:0] in_addr_o, out_addr_o;
   logic [7:0] q;
   ued_hs_t in_hs_o, out_hs_o;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   always #10 clk_i = ~clk_i;
   ued_endpoint_desc dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .in_tok_i(in_tok), .in_done_i(in_done), .in_stall_set_i(stall_set),
      .in_hs_o(in_hs_o), .in_resp_o(in_resp_o), .in_addr_o(in_addr_o), .in_cnt_o(in_cnt_o),
      .out_tok_i(out_tok), .out_done_i(out_done), .out_len_i(out_len), .out_buffer_manager_enable_i(buffer_manager_enable),
      .out_irq_en_i(oirq), .out_hs_o(out_hs_o), .out_resp_o(out_resp_o),
      .out_addr_o(out_addr_o), .out_size_o(out_size_o), .irq_o(irq_o));
   ued_host_model host (.clk_i(clk_i), .in_resp_i(in_resp_o), .out_resp_i(out_resp_o),
      .in_tok_o(in_tok), .in_done_o(in_done), .out_tok_o(out_tok), .out_done_o(out_done),
      .out_len_o(out_len));
   // ****
   // Tasks
   // ****
   task automatic end_sim();
      $display("Mismatches %0d in %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [4:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {1'b0, idx, 2'b00};
      wdat <= {24'h00_0000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      cyc <= 1'b0;
   endtask : wb
   task automatic rd(input logic [4:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00);
      chk(16'(q), 16'(e));
   endtask : rd
   task automatic tx(input logic o, input logic d, input ued_hs_t h, input logic [10:0] a,
      input logic [6:0] c);
      host.xfer(o, d, c, got);
      chk(16'(got), 16'(h != UED_HS_NONE));
      chk(16'(o ? out_hs_o : in_hs_o), 16'(h));
      if (h == UED_HS_ACK) begin
         chk(16'(o ? out_addr_o : in_addr_o), 16'(a));
         chk(16'(o ? out_size_o : in_cnt_o), 16'(c));
      end
   endtask : tx
   // ****
   // Scenarios
   // ****
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         rd(5'(i), 8'h00);
      end
      wb(1'b1, IDX_IN_CFG, 8'hBF);
      rd(IDX_IN_CFG, 8'hBC);
      wb(1'b1, IDX_OUT_SIZE, 8'hFF);
      rd(IDX_OUT_SIZE, 8'h7F);
      wb(1'b1, IDX_IN_X_BASE, 8'hA5);
      wb(1'b1, IDX_IN_X_CNT, 8'h05);
      wb(1'b1, IDX_IRQ_EN, 8'h07);
      wb(1'b1, IDX_IN_CFG, 8'h84);
      tx(1'b0, 1'b1, UED_HS_ACK, 11'h528, 7'h05);
      rd(IDX_IN_CFG, 8'hA4);
      rd(IDX_IN_X_CNT, 8'h85);
      rd(IDX_IN_X_BASE, 8'hA5);
      chk(16'(irq_o), 16'h0001);
      tx(1'b0, 1'b0, UED_HS_NAK, 11'h528, 7'h05);
      wb(1'b1, IDX_IRQ_CLR, 8'h01);
      rd(IDX_IRQ_STAT, 8'h00);
      chk(16'(irq_o), 16'h0000);
      wb(1'b1, IDX_IN_Y_BASE, 8'h11);
      wb(1'b1, IDX_IN_Y_CNT, 8'h02);
      wb(1'b1, IDX_IN_CFG, 8'hB0);
      tx(1'b0, 1'b1, UED_HS_ACK, 11'h088, 7'h02);
      rd(IDX_IN_Y_CNT, 8'h82);
      wb(1'b1, IDX_IN_X_CNT, 8'h03);
      wb(1'b1, IDX_IN_CFG, 8'h90);
      tx(1'b0, 1'b0, UED_HS_ACK, 11'h528, 7'h03);
      wb(1'b1, IDX_IN_CFG, 8'hA0);
      tx(1'b0, 1'b1, UED_HS_ACK, 11'h528, 7'h03);
      rd(IDX_IRQ_STAT, 8'h00);
      wb(1'b1, IDX_IN_X_CNT, 8'h03);
      wb(1'b1, IDX_IN_CFG, 8'h88);
      tx(1'b0, 1'b0, UED_HS_STALL, 11'h528, 7'h03);
      rd(IDX_IN_CFG, 8'h80);
      tx(1'b0, 1'b0, UED_HS_ACK, 11'h528, 7'h03);
      @(posedge clk_i);
      stall_set <= 1'b1;
      @(posedge clk_i);
      stall_set <= 1'b0;
      rd(IDX_IN_CFG, 8'h88);
      wb(1'b1, IDX_IN_CFG, 8'h08);
      tx(1'b0, 1'b0, UED_HS_NONE, 11'h528, 7'h03);
      rd(IDX_IN_CFG, 8'h08);
      wb(1'b1, IDX_IRQ_CLR, 8'h07);
      wb(1'b1, IDX_OUT_Y_BASE, 8'h40);
      wb(1'b1, IDX_OUT_SIZE, 8'h40);
      wb(1'b1, IDX_OUT_Y_CNT, 8'h00);
      buffer_manager_enable <= 1'b1;
      oirq <= 1'b1;
      tx(1'b1, 1'b1, UED_HS_ACK, 11'h200, 7'h40);
      rd(IDX_OUT_Y_CNT, 8'hC0);
      rd(IDX_IRQ_STAT, 8'h02);
      wb(1'b1, IDX_IRQ_CLR, 8'h02);
      wb(1'b1, IDX_OUT_Y_CNT, 8'h00);
      // Out completion with its interrupt enable low
      oirq <= 1'b0;
      tx(1'b1, 1'b1, UED_HS_ACK, 11'h200, 7'h40);
      rd(IDX_IRQ_STAT, 8'h00);
      tx(1'b1, 1'b0, UED_HS_NAK, 11'h200, 7'h40);
      buffer_manager_enable <= 1'b0;
      tx(1'b1, 1'b0, UED_HS_NONE, 11'h200, 7'h40);
      end_sim();
   end
endmodule : tb_ued_endpoint_desc
`default_nettype wire

/* File: test/ued_endpoint_desc_assertions.sv */
// Port checks for the endpoint descriptor block
`timescale 1ns/10ps
`default_nettype none
module ued_endpoint_desc_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Transactions
   input wire logic in_tok_i,
   input wire logic in_done_i,
   input wire logic out_tok_i,
   input wire logic out_done_i,
   input wire logic out_buffer_manager_enable_i,
   input var ued_pkg::ued_hs_t in_hs_o,
   input var ued_pkg::ued_hs_t out_hs_o,
   input wire logic in_resp_o,
   input wire logic out_resp_o,
   input wire logic [10:0] in_addr_o,
   input wire logic [10:0] out_addr_o,
   input wire logic irq_o
);
   import ued_pkg::*;
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack; s_req |=> s_ack_once; endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer missing or too long");
   property p_in_pad; in_addr_o[2:0] == 3'h0; endproperty
   a_in_pad: assert property (p_in_pad)
      else $error("in start address not padded");
   property p_out_pad; out_addr_o[2:0] == 3'h0; endproperty
   a_out_pad: assert property (p_out_pad)
      else $error("out start address not padded");
   property p_in_hold; $changed(in_addr_o) |-> in_resp_o && in_hs_o == UED_HS_ACK; endproperty
   a_in_hold: assert property (p_in_hold)
      else $error("in address moved without a served token");
   property p_out_hold; $changed(out_addr_o) |-> out_resp_o && out_hs_o == UED_HS_ACK; endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("out address moved without a served token");
   property p_in_gate; in_resp_o |-> $past(in_tok_i) && in_hs_o != UED_HS_NONE; endproperty
   a_in_gate: assert property (p_in_gate)
      else $error("in answer without token");
   property p_out_gate;
      out_resp_o |-> $past(out_tok_i) && $past(out_buffer_manager_enable_i) && out_hs_o inside {UED_HS_ACK, UED_HS_NAK};
   endproperty
   a_out_gate: assert property (p_out_gate)
      else $error("out answer bad");
   property p_irq_rise;
      $rose(irq_o) |-> $past(in_done_i, 2) || $past(out_done_i, 2) || $past(wb_ack_o) || $past(in_resp_o);
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt rose without cause");
   property p_irq_fall; $fell(irq_o) |-> $past(wb_ack_o); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt fell without a write");
endmodule : ued_endpoint_desc_assertions
bind ued_endpoint_desc ued_endpoint_desc_assertions u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .in_tok_i(in_tok_i), .in_done_i(in_done_i), .out_tok_i(out_tok_i),
   .out_done_i(out_done_i), .out_buffer_manager_enable_i(out_buffer_manager_enable_i), .in_hs_o(in_hs_o), .out_hs_o(out_hs_o),
   .in_resp_o(in_resp_o), .out_resp_o(out_resp_o), .in_addr_o(in_addr_o),
   .out_addr_o(out_addr_o), .irq_o(irq_o)
);
`default_nettype wire

/* File: test/ued_host_model.sv */
// Host side model: tokens and completion pulses
`timescale 1ns/10ps
`default_nettype none
module ued_host_model (
   // Clock and answers
   input wire logic clk_i,
   input wire logic in_resp_i,
   input wire logic out_resp_i,
   // Pulses and the out length to the block
   output logic in_tok_o,
   output logic in_done_o,
   output logic out_tok_o,
   output logic out_done_o,
   output logic [6:0] out_len_o
);
   // ****
   // Transfer task
   // ****
   initial begin
      in_tok_o = 1'b0;
      in_done_o = 1'b0;
      out_tok_o = 1'b0;
      out_done_o = 1'b0;
      out_len_o = 7'h00;
   end
   // Bounded wait, so a silent block never hangs the host
   task automatic xfer(input logic o, input logic d, input logic [6:0] len, output logic got);
      @(posedge clk_i);
      in_tok_o <= !o;
      out_tok_o <= o;
      @(posedge clk_i);
      in_tok_o <= 1'b0;
      out_tok_o <= 1'b0;
      got = 1'b0;
      repeat (3) begin
         @(posedge clk_i);
         got = got | (o ? out_resp_i : in_resp_i);
      end
      if (d && got) begin
         out_len_o <= (len > 7'h40) ? 7'h40 : len;
         in_done_o <= !o;
         out_done_o <= o;
         @(posedge clk_i);
         in_done_o <= 1'b0;
         out_done_o <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
   endtask : xfer
endmodule : ued_host_model
`default_nettype wire
